// [core/sar_pkg.sv]
// constants, types and rule summary for the converter control and serial readout
// Operation
// - convert_start rising edge begins a conversion and powers up the core.
// - a conversion in progress is never restarted by further convert_start edges.
// - busy stays high for the whole conversion, low once it has finished.
// - internal timing finishes each conversion within 412ns, no external clock.
// - on completion the core powers down and tracks the input again.
// - while powered down the previous result can still be shifted out.
// - supply below 1V resets the device; it reinitialises when supply returns.
// - bits shift out only on shift clock edges while the output is enabled.
// - output changes on rising shift edge; host samples falling or next rising.
// - result_msb stays on the output until the first rising shift edge.
// - normal mode: read_enable high floats the output, low drives it.
// - normal mode, read_enable low: new result_msb appears when busy falls; here it waits in the fifo while a read is part done.
// - normal mode: read_enable falling presents stored result_msb at once.
// - chain mode: output always driven, read_enable pin is upstream data.
// - chain mode: upstream bit captured each rising edge, MSB out after 18.
// - result is unsigned straight binary over 18 bits.

package sar_pkg;

    // ==========================================================
    // widths and depths
    localparam int RES_W       = 18;
    localparam int FIFO_DEPTH  = 16;
    localparam int BITS_W      = 5;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_MAX_NS   = 412;
    // longest time rounds down
    localparam int CONV_CYC      = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CYC_W         = 4;

    // ==========================================================
    // positions of the pin inputs in the synchroniser vector
    localparam int PIN_N     = 5;
    localparam int PIN_CONV  = 0;
    localparam int PIN_SCK   = 1;
    localparam int PIN_RDIN  = 2;
    localparam int PIN_CHAIN = 3;
    localparam int PIN_SUPPLY = 4;

    // ==========================================================
    // reset values
    localparam logic [RES_W-1:0] RESULT_RST = 18'h00000;
    localparam logic [BITS_W-1:0] BITS_RST  = 5'h00;

    // ==========================================================
    // conversion sequencer
    typedef enum logic [1:0]
    {
        SAR_IDLE = 2'b00,
        SAR_CONV = 2'b01,
        SAR_PUSH = 2'b10
    } sar_state_t;

endpackage

// [core/sar_core.sv]
// conversion sequencer, result fifo and serial readout shifter
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// result fifo
module sar_fifo
    import sar_pkg::*;
#(
    parameter int WIDTH = RES_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    // address width; the pointers carry one bit more
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad_depth
            $error("sar_fifo depth must be a power of two, at least 2");
        end
        if (WIDTH < 1)
        begin : g_bad_width
            $error("sar_fifo width must be positive");
        end
    endgenerate

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sar_fifo_st_t;

    sar_fifo_st_t     q;
    sar_fifo_st_t     d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             full;
    logic             empty;
    logic             do_wr;
    logic             do_rd;

    // ==========================================================
    // flags
    // extra pointer bit tells full from empty
    assign full      = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign empty     = (q.wp == q.rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[q.rp[AW-1:0]];
    assign do_wr     = in_valid && !full;
    assign do_rd     = out_ready && !empty;

    // ==========================================================
    // pointers; a flush wins over a write or a read in the same cycle
    always_comb
    begin
        d = q;
        if (do_wr)
        begin
            d.wp = q.wp + 1'b1;
        end
        if (do_rd)
        begin
            d.rp = q.rp + 1'b1;
        end
        if (flush)
        begin
            d.wp = '0;
            d.rp = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // storage is not reset; out_data only matters while out_valid is high
    always_ff @(posedge sys_clk)
    begin
        if (do_wr)
        begin
            mem[q.wp[AW-1:0]] <= in_data;
        end
    end

endmodule

// ==========================================================
// converter top
module sar_core
    import sar_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             convert_start,
    input  wire logic             sck,
    input  wire logic             read_enable_or_upstream_in,
    input  wire logic             chain_mode,
    input  wire logic             supply_good,
    input  wire logic [RES_W-1:0] conv_code,
    output logic                  busy,
    output logic                  sdo,
    output logic                  sdo_oe,
    output logic                  core_powered
);

    // the sequencer counts down from CONV_CYC-3, the shifter up to RES_W
    generate
        if (CONV_CYC < 3 || CONV_CYC >= (1 << CYC_W))
        begin : g_bad_conv
            $error("sar_core conversion count out of range");
        end
        if (RES_W >= (1 << BITS_W))
        begin : g_bad_bits
            $error("sar_core bit counter too narrow");
        end
    endgenerate

    // s1 and s2 synchronise the pins; prev holds s2 of the cycle before
    typedef struct packed {
        logic [PIN_N-1:0]  s1;
        logic [PIN_N-1:0]  s2;
        logic [PIN_N-1:0]  prev;
        sar_state_t        st;
        logic [CYC_W-1:0]  cyc;
        logic [RES_W-1:0]  result;
        logic [RES_W-1:0]  held;
        logic [RES_W-1:0]  sreg;
        logic [BITS_W-1:0] bits;
        logic              busy;
        logic              sdo;
        logic              oe;
        logic              pwr;
    } sar_core_st_t;

    localparam sar_core_st_t CORE_RST = '{
        s1:     '0,
        s2:     '0,
        prev:   '0,
        st:     SAR_IDLE,
        cyc:    '0,
        result: RESULT_RST,
        held:   RESULT_RST,
        sreg:   RESULT_RST,
        bits:   BITS_RST,
        busy:   1'b0,
        sdo:    1'b0,
        oe:     1'b0,
        pwr:    1'b0
    };

    sar_core_st_t     q;
    sar_core_st_t     d;
    logic             f_in_ready;
    logic             f_out_valid;
    logic             f_out_ready;
    logic [RES_W-1:0] f_out_data;
    logic             conv_rise;
    logic             sck_rise;
    logic             rd_fall;
    logic             chain;
    logic             enabled;
    logic             mid_read;
    logic             supply_lost;

    assign conv_rise   = q.s2[PIN_CONV] && !q.prev[PIN_CONV];
    // sck is slow against sys_clk, so one pin edge gives one detected pulse
    assign sck_rise    = q.s2[PIN_SCK] && !q.prev[PIN_SCK];
    assign rd_fall     = !q.s2[PIN_RDIN] && q.prev[PIN_RDIN];
    assign chain       = q.s2[PIN_CHAIN];
    assign enabled     = chain || !q.s2[PIN_RDIN];
    assign supply_lost = !q.s2[PIN_SUPPLY];
    // a partly shifted word is not overwritten by the next result
    // the fifo holds results meanwhile; after the read they load one per cycle, so only the last one stays
    assign mid_read    = (q.bits != BITS_RST) && (q.bits < BITS_W'(RES_W));
    assign f_out_ready = !mid_read && !supply_lost;

    sar_fifo #(
        .WIDTH (RES_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .flush     (supply_lost),
        .in_valid  (q.st == SAR_PUSH),
        .in_ready  (f_in_ready),
        .in_data   (q.result),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb
    begin
        d      = q;

        // ==========================================================
        // pin synchronisers, then one more flop to find edges
        d.s1   = {supply_good, chain_mode, read_enable_or_upstream_in, sck, convert_start};
        d.s2   = q.s1;
        d.prev = q.s2;

        // ==========================================================
        // conversion sequencer
        unique case (q.st)
            SAR_IDLE:
            begin
                if (q.busy)
                begin
                    // unless a read is part done, the pushed word reaches the shifter on this edge, so busy falls
                    // together with result_msb appearing on sdo
                    // a start edge seen now is dropped: the run is not complete yet
                    d.busy = 1'b0;
                end
                else if (conv_rise)
                begin
                    d.st   = SAR_CONV;
                    // one cycle pushes and one drops busy, so busy lasts CONV_CYC cycles
                    d.cyc  = CYC_W'(CONV_CYC - 3);
                    d.busy = 1'b1;
                    d.pwr  = 1'b1;
                end
            end
            SAR_CONV:
            begin
                // start edges are not looked at here
                if (q.cyc == '0)
                begin
                    d.st     = SAR_PUSH;
                    d.result = conv_code;
                    d.pwr    = 1'b0;
                end
                else
                begin
                    d.cyc = q.cyc - 1'b1;
                end
            end
            SAR_PUSH:
            begin
                // a full fifo keeps busy high until room appears
                // busy itself drops on the next edge, when the word can reach the shifter
                if (f_in_ready)
                begin
                    d.st = SAR_IDLE;
                end
            end
            default:
            begin
                d.st = SAR_IDLE;
            end
        endcase

        // ==========================================================
        // readout shifter
        // a new word wins over a shift edge in the same cycle; that edge is lost
        if (f_out_valid && f_out_ready)
        begin
            d.sreg = f_out_data;
            d.held = f_out_data;
            d.bits = BITS_RST;
        end
        else if (sck_rise && enabled)
        begin
            // msb first, upstream bit enters at the bottom in chain mode
            d.sreg = {q.sreg[RES_W-2:0], chain && q.s2[PIN_RDIN]};
            if (q.bits < BITS_W'(RES_W))
            begin
                d.bits = q.bits + 1'b1;
            end
        end
        else if (!chain && rd_fall)
        begin
            d.sreg = q.held;
            d.bits = BITS_RST;
        end

        // until the first rising edge the msb simply stays put
        d.sdo = d.sreg[RES_W-1];
        // sdo_oe follows the pin levels, not the sck edges
        d.oe  = chain || !q.s2[PIN_RDIN];

        // ==========================================================
        // supply loss puts the core back to its initial state
        // the fifo is emptied through its flush input in the same cycle
        if (supply_lost)
        begin
            d.st     = SAR_IDLE;
            d.cyc    = '0;
            d.busy   = 1'b0;
            d.pwr    = 1'b0;
            d.result = RESULT_RST;
            d.held   = RESULT_RST;
            d.sreg   = RESULT_RST;
            d.bits   = BITS_RST;
            d.sdo    = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            q <= CORE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign busy         = q.busy;
    assign sdo          = q.sdo;
    assign sdo_oe       = q.oe;
    assign core_powered = q.pwr;

endmodule

`default_nettype wire

// [verif/sar_chk.sv]
// concurrent checks on the converter top's pins
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// checker
module sar_chk
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic convert_start,
    input wire logic sck,
    input wire logic read_enable_or_upstream_in,
    input wire logic chain_mode,
    input wire logic supply_good,
    input wire logic busy,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic core_powered
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // pins pass two flops, so levels must hold a few cycles before outputs follow
    sequence s_start;
        !busy && supply_good && $rose(convert_start);
    endsequence
    sequence s_run;
        $rose(busy) ##0 core_powered;
    endsequence

    chk_start_busy: assert property (s_start |-> ##[1:6] busy)
        else $error("start not taken");
    // a supply loss cuts a run short on purpose, so the run timing checks stand down then
    chk_run_power: assert property (disable iff (!resetn || !supply_good)
        s_run |=> core_powered[*5] ##1 !core_powered)
        else $error("core power time wrong");
    chk_busy_min: assert property (disable iff (!resetn || !supply_good)
        $rose(busy) |-> busy[*8])
        else $error("busy too short");
    chk_busy_end: assert property (disable iff (!resetn || !supply_good)
        $rose(busy) |-> ##8 !busy)
        else $error("busy too long");
    chk_no_restart: assert property (busy && !core_powered |=> !core_powered)
        else $error("conversion restarted");
    chk_supply_rst: assert property (!supply_good[*4] |-> !busy && !core_powered)
        else $error("supply loss kept state");
    chk_oe_float: assert property ((!chain_mode && read_enable_or_upstream_in)[*4] |-> !sdo_oe)
        else $error("sdo driven while disabled");
    chk_oe_drive: assert property ((!chain_mode && !read_enable_or_upstream_in)[*4] |-> sdo_oe)
        else $error("sdo not driven");
    chk_sdo_quiet: assert property ((!sck && !busy && supply_good && !chain_mode
        && !read_enable_or_upstream_in)[*6] |-> $stable(sdo))
        else $error("sdo moved without shift");
endmodule

bind sar_core sar_chk chk_u (.sys_clk, .resetn, .convert_start, .sck,
    .read_enable_or_upstream_in, .chain_mode, .supply_good, .busy, .sdo, .sdo_oe,
    .core_powered);
`default_nettype wire

// [verif/sar_host.sv]
// host readout model: shift clock bursts and sdo capture
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host
module sar_host
    import sar_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             go,
    input  wire logic             sdo,
    input  wire logic             sdo_oe,
    output logic                  sck,
    output logic      [RES_W-1:0] word,
    output int                    words
);
    // a floating line reads as the inverse, so a disabled output never matches
    initial
    begin
        sck   = 1'b0;
        word  = '0;
        words = 0;
        forever
        begin
            @(posedge go);
            for (int i = 0; i < RES_W; i++)
            begin
                word = {word[RES_W-2:0], sdo_oe ? sdo : ~sdo};
                sck  = 1'b1;
                repeat (4) @(negedge sys_clk);
                sck  = 1'b0;
                repeat (4) @(negedge sys_clk);
            end
            words++;
        end
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the converter top
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench
module tb
    import sar_pkg::*;
;
    logic             sys_clk, resetn, convert_start, rde, chain_mode, supply_good, go;
    logic             sck, busy, sdo, sdo_oe, core_powered;
    logic             late_edges;
    logic [RES_W-1:0] conv_code, word;
    int               err_count, n_checks, words;

    sar_core dut_u (.sys_clk, .resetn, .convert_start, .sck, .read_enable_or_upstream_in(rde),
        .chain_mode, .supply_good, .conv_code, .busy, .sdo, .sdo_oe, .core_powered);
    sar_host host_u (.sys_clk, .go, .sdo, .sdo_oe, .sck, .word, .words);

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task report_and_stop;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask

    task fail_stop;
        err_count++;
        report_and_stop();
    endtask

    task wait_busy(input logic v);
        for (int k = 0; k < 20 && busy !== v; k++)
            @(negedge sys_clk);
        if (busy !== v)
            fail_stop();
    endtask

    task read_word;
        int n;
        n = words;
        go <= 1'b1;
        for (int k = 0; k < 200 && words == n; k++)
            @(negedge sys_clk);
        go <= 1'b0;
        if (words == n)
            fail_stop();
        @(negedge sys_clk);
    endtask

    task convert(input logic [RES_W-1:0] code);
        int k;
        repeat (4) @(negedge sys_clk);
        conv_code     <= code;
        convert_start <= 1'b1;
        wait_busy(1'b1);
        check(core_powered, 1'b1);
        // late_edges pulses convert_start twice during the run on purpose, to show a run is not restarted;
        // otherwise the pin drops just after busy is seen high and stays low
        for (k = 0; k < 20 && busy === 1'b1; k++)
        begin
            convert_start <= late_edges && (k < 4) && k[0];
            @(negedge sys_clk);
        end
        check(k[RES_W-1:0], RES_W'(CONV_CYC));
        check(core_powered, 1'b0);
    endtask

    task test_normal(input logic [RES_W-1:0] code);
        chain_mode <= 1'b0;
        rde        <= 1'b0;
        convert(code);
        // busy has just been seen low: result_msb must already stand
        check(sdo, code[RES_W-1]);
        check(sdo_oe, 1'b1);
        read_word();
        check(word, code);
        check(busy, 1'b0);
    endtask

    task test_disabled(input logic [RES_W-1:0] code);
        rde <= 1'b1;
        convert(code);
        repeat (3) @(negedge sys_clk);
        check(sdo_oe, 1'b0);
        read_word();
        // a floating sdo reads inverted, and no edge may have shifted it
        check(word, {RES_W{~code[RES_W-1]}});
        rde <= 1'b0;
        repeat (5) @(negedge sys_clk);
        check(sdo_oe, 1'b1);
        check(sdo, code[RES_W-1]);
        read_word();
        check(word, code);
    endtask

    task test_chain(input logic [RES_W-1:0] code);
        chain_mode <= 1'b1;
        rde        <= 1'b1;
        convert(code);
        repeat (3) @(negedge sys_clk);
        check(sdo_oe, 1'b1);
        read_word();
        check(word, code);
        check(sdo, 1'b1);
        chain_mode <= 1'b0;
    endtask

    task test_supply(input logic [RES_W-1:0] code);
        rde           <= 1'b1;
        convert_start <= 1'b1;
        wait_busy(1'b1);
        convert_start <= 1'b0;
        supply_good   <= 1'b0;
        repeat (5) @(negedge sys_clk);
        check(busy, 1'b0);
        check(core_powered, 1'b0);
        supply_good <= 1'b1;
        repeat (4) @(negedge sys_clk);
        rde <= 1'b0;
        repeat (5) @(negedge sys_clk);
        check(sdo, RESULT_RST[RES_W-1]);
        repeat (400) @(negedge sys_clk);
        test_normal(code);
    endtask

    initial
    begin
        err_count     = 0;
        n_checks      = 0;
        resetn        = 1'b0;
        convert_start = 1'b0;
        rde           = 1'b0;
        chain_mode    = 1'b0;
        supply_good   = 1'b1;
        go            = 1'b0;
        late_edges    = 1'b1;
        conv_code     = '0;
        repeat (6) @(negedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        test_normal(18'h2a5c3);
        late_edges = 1'b0;
        test_normal(18'h0001f);
        test_disabled(18'h3fffe);
        test_chain(18'h15554);
        test_supply(18'h20001);
        report_and_stop();
    end
endmodule
`default_nettype wire
